// File: src/sscc_conv_ctrl.sv
// conversion start, sequencing, result banks and register port
// assumes pins synchronous to clk; analog core returns coreSample
// for the channel on coreChannel at the end of each slot
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sscc_regs.svh"

module sscc_conv_ctrl
    import sscc_pkg::*;
#(
    parameter int STANDBY_CONTROL_WAKE_CYC = `SSCC_STANDBY_CONTROL_WAKE_CYC,
    parameter int SHDN_WAKE_CYC = `SSCC_SHDN_WAKE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire sscc_bus_t   regBus,
    output logic      [31:0] rdData,
    output logic             irq,
    input  wire logic        standbyControl,
    input  wire logic        rangeSelect,
    input  wire logic        deviceReset,
    input  wire logic        sampleStartA,
    input  wire logic        sampleStartB,
    input  wire logic        oversampleOn,
    input  wire logic [15:0] coreSample,
    output logic             busy,
    output logic             holdLow,
    output logic             holdHigh,
    output logic      [2:0]  coreChannel,
    output logic             rangeApplied,
    output logic             refPowered,
    output logic             corePowered,
    output logic             deviceReady
);
    logic       rstPipe_reg;
    logic       rstnSync;
    sscc_pwr_t  pwrMode;
    logic       pwrReady;
    logic       wakeEvt;
    logic [15:0] memQ;
    logic       memWr;
    logic [3:0] memWrAddr;
    logic       riseA;
    logic       riseB;
    logic       startA;
    logic       startB;
    logic [`SSCC_EVT_W-1:0] evt;
    sscc_core_t st_reg;
    sscc_core_t st_next;

    function automatic logic [31:0] widen3(input logic [2:0] v);
        widen3 = {29'h00000000, v};
    endfunction : widen3

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe_reg <= 1'b0;
            rstnSync    <= 1'b0;
        end else begin
            rstPipe_reg <= 1'b1;
            rstnSync    <= rstPipe_reg;
        end
    end

    sscc_power_ctrl #(
        .STANDBY_CONTROL_WAKE_CYC (STANDBY_CONTROL_WAKE_CYC),
        .SHDN_WAKE_CYC (SHDN_WAKE_CYC)
    ) u_power (
        .clk            (clk),
        .rstn           (rstnSync),
        .standbyControl (standbyControl),
        .rangeSelect    (rangeSelect),
        .deviceReset    (deviceReset),
        .pwrMode        (pwrMode),
        .refOn          (refPowered),
        .coreOn         (corePowered),
        .ready          (pwrReady),
        .wakeEvt        (wakeEvt)
    );

    sscc_result_mem u_mem (
        .clk    (clk),
        .rstn   (rstnSync),
        .wrEn   (memWr),
        .wrAddr (memWrAddr),
        .wrData (coreSample),
        .rdAddr ({st_next.bank, st_next.rdPtr}),
        .rdData (memQ)
    );

    assign riseA = sampleStartA && !st_reg.prevA;
    assign riseB = sampleStartB && !st_reg.prevB;
    // oversampling forbids split sets, so either edge starts all channels
    assign startA = oversampleOn ? (riseA || riseB) : riseA;
    assign startB = oversampleOn ? (riseA || riseB) : riseB;

    always_comb begin
        st_next        = st_reg;
        st_next.prevA  = sampleStartA;
        st_next.prevB  = sampleStartB;
        st_next.rdData = 32'h00000000;
        memWr          = 1'b0;
        memWrAddr      = {!st_reg.bank, st_reg.chan};
        evt            = '0;
        evt[`SSCC_EVT_WAKE] = wakeEvt;
        case (st_reg.cst)
            SSCC_CST_IDLE, SSCC_CST_ARMED: begin
                if (!pwrReady) begin
                    st_next.cst   = SSCC_CST_IDLE;
                    st_next.holdA = 1'b0;
                    st_next.holdB = 1'b0;
                    evt[`SSCC_EVT_IGNORED] = riseA || riseB;
                end else begin
                    if (startA) begin
                        st_next.holdA = 1'b1;
                    end
                    if (startB) begin
                        st_next.holdB = 1'b1;
                    end
                    if (st_next.holdA && st_next.holdB) begin
                        // the later of the two edges starts conversion
                        st_next.cst  = SSCC_CST_CONV;
                        st_next.busy = 1'b1;
                        st_next.slot = 6'h00;
                        st_next.chan = 3'h0;
                    end else if (st_next.holdA || st_next.holdB) begin
                        st_next.cst = SSCC_CST_ARMED;
                    end
                end
            end
            SSCC_CST_CONV: begin
                evt[`SSCC_EVT_IGNORED] = riseA || riseB;
                if (!pwrReady) begin
                    st_next.cst   = SSCC_CST_IDLE;
                    st_next.busy  = 1'b0;
                    st_next.holdA = 1'b0;
                    st_next.holdB = 1'b0;
                end else if (st_reg.slot == 6'(`SSCC_SLOT_CYC - 1)) begin
                    memWr        = 1'b1;
                    st_next.slot = 6'h00;
                    if (st_reg.chan == 3'(`SSCC_NCHAN - 1)) begin
                        st_next.cst   = SSCC_CST_IDLE;
                        st_next.busy  = 1'b0;
                        st_next.holdA = 1'b0;
                        st_next.holdB = 1'b0;
                        // fresh bank becomes the readout bank
                        st_next.bank  = !st_reg.bank;
                        st_next.rdPtr = 3'h0;
                        evt[`SSCC_EVT_DONE] = 1'b1;
                    end else begin
                        st_next.chan = st_reg.chan + 3'h1;
                    end
                end else begin
                    st_next.slot = st_reg.slot + 6'h01;
                end
            end
            default: st_next.cst = SSCC_CST_IDLE;
        endcase

        if (deviceReset) begin
            st_next.rangeCfg = rangeSelect;
            st_next.cst      = SSCC_CST_IDLE;
            st_next.busy     = 1'b0;
            st_next.holdA    = 1'b0;
            st_next.holdB    = 1'b0;
            st_next.rdPtr    = 3'h0;
        end

        if (regBus.rd) begin
            case (regBus.addr)
                `SSCC_OFS_STATUS: st_next.rdData = widen3(st_reg.status);
                `SSCC_OFS_MASK:   st_next.rdData = widen3(st_reg.mask);
                `SSCC_OFS_STATE:  st_next.rdData = {20'h00000, st_reg.rdPtr,
                    st_reg.bank, st_reg.rangeCfg, pwrMode, pwrReady,
                    st_reg.busy, st_reg.holdB, st_reg.holdA};
                `SSCC_OFS_RESULT: begin
                    // results always come from the finished bank
                    st_next.rdData = {16'h0000, memQ};
                    if (!deviceReset && !evt[`SSCC_EVT_DONE]) begin
                        st_next.rdPtr = st_reg.rdPtr + 3'h1;
                    end
                end
                default: st_next.rdData = 32'h00000000;
            endcase
        end

        // a new event beats a simultaneous clear
        st_next.status = st_reg.status;
        if (regBus.wr && regBus.addr == `SSCC_OFS_STATUS) begin
            st_next.status = st_reg.status & ~regBus.wdata[2:0];
        end
        st_next.status = st_next.status | evt;
        if (regBus.wr && regBus.addr == `SSCC_OFS_MASK) begin
            st_next.mask = regBus.wdata[2:0];
        end
        st_next.irq = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            st_reg <= '{cst: SSCC_CST_IDLE, prevA: 1'b1, prevB: 1'b1,
                        holdA: 1'b0, holdB: 1'b0, busy: 1'b0,
                        slot: 6'h00, chan: 3'h0, bank: 1'b0,
                        rdPtr: 3'h0, rangeCfg: 1'b0, status: 3'h0,
                        mask: `SSCC_MASK_RESET, irq: 1'b0,
                        rdData: 32'h00000000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdData       = st_reg.rdData;
    assign irq          = st_reg.irq;
    assign busy         = st_reg.busy;
    assign holdLow      = st_reg.holdA;
    assign holdHigh     = st_reg.holdB;
    assign coreChannel  = st_reg.chan;
    assign rangeApplied = st_reg.rangeCfg;
    assign deviceReady  = pwrReady;

    logic [8:0] busyLen;
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            busyLen <= 9'h000;
        end else begin
            busyLen <= st_reg.busy ? busyLen + 9'h001 : 9'h000;
        end
    end

    default clocking ccb @(posedge clk); endclocking
    default disable iff (!rstnSync);

    sequence armedOnA;
        st_reg.cst == SSCC_CST_ARMED && st_reg.holdA && !st_reg.holdB;
    endsequence
    sequence laterEdgeB;
        riseB && !oversampleOn && pwrReady && !deviceReset;
    endsequence

    AST_BUSY_LEN: assert property (
        ($fell(st_reg.busy) && $past(pwrReady) && !$past(deviceReset))
        |-> busyLen == 9'(`SSCC_CONV_CYC))
        else $error("conversion length wrong");
    AST_HOLD_TRACK: assert property (
        $fell(st_reg.busy) |-> (!st_reg.holdA && !st_reg.holdB))
        else $error("hold not released at busy fall");
    AST_BUSY_BOTH: assert property (
        $rose(st_reg.busy) |-> (st_reg.holdA && st_reg.holdB
                                && st_reg.chan == 3'h0))
        else $error("busy without both sets held");
    AST_LATER_EDGE: assert property (
        (armedOnA and laterEdgeB) |=> st_reg.busy ##1 st_reg.busy)
        else $error("later edge did not start conversion");
    AST_SINGLE_EDGE: assert property (
        (st_reg.cst == SSCC_CST_IDLE && riseA && !sampleStartB
         && !st_reg.prevB && !oversampleOn && pwrReady && !deviceReset)
        |=> (st_reg.holdA && !st_reg.holdB && !st_reg.busy))
        else $error("start A alone must hold only first set");
    AST_IGNORE: assert property (
        (st_reg.busy && (riseA || riseB) && pwrReady && !deviceReset
         && st_reg.chan != 3'(`SSCC_NCHAN - 1))
        |=> (st_reg.busy && $stable(st_reg.chan) || st_reg.slot == 6'h00))
        else $error("start edge disturbed conversion");
    AST_RESULT_FRESH: assert property (
        $fell(st_reg.busy) && pwrReady && !$past(deviceReset)
        |-> (st_reg.rdPtr == 3'h0 && st_reg.bank != $past(st_reg.bank)
             && st_reg.status[`SSCC_EVT_DONE]))
        else $error("new results not published at busy fall");
    AST_READ_PREV: assert property (
        (st_reg.busy && regBus.rd && regBus.addr == `SSCC_OFS_RESULT)
        |-> (memWrAddr[3] != st_reg.bank)
            ##1 (rdData == {16'h0000, $past(memQ)}))
        else $error("read during busy not from previous bank");
endmodule : sscc_conv_ctrl

`default_nettype wire

// File: include/sscc_regs.svh
// constants for the simultaneous sample conversion control block
// assumes a 100 MHz system clock; included by bare name
`ifndef SSCC_REGS_SVH
`define SSCC_REGS_SVH

`define SSCC_CLK_MHZ        100
`define SSCC_NCHAN          8
`define SSCC_CONV_US        4
`define SSCC_CONV_CYC       (`SSCC_CONV_US * `SSCC_CLK_MHZ)
`define SSCC_SLOT_CYC       (`SSCC_CONV_CYC / `SSCC_NCHAN)
`define SSCC_STANDBY_CONTROL_WAKE_US   100
`define SSCC_STANDBY_CONTROL_WAKE_CYC  (`SSCC_STANDBY_CONTROL_WAKE_US * `SSCC_CLK_MHZ)
`define SSCC_SHDN_WAKE_US   13000
`define SSCC_SHDN_WAKE_CYC  (`SSCC_SHDN_WAKE_US * `SSCC_CLK_MHZ)

`define SSCC_OFS_STATUS     8'h00
`define SSCC_OFS_MASK       8'h04
`define SSCC_OFS_STATE      8'h08
`define SSCC_OFS_RESULT     8'h0c

`define SSCC_EVT_DONE       0
`define SSCC_EVT_IGNORED    1
`define SSCC_EVT_WAKE       2
`define SSCC_EVT_W          3
`define SSCC_MASK_RESET     3'h0

`endif

// File: include/sscc_pkg.sv
// types of the simultaneous sample conversion control block
// assumes sscc_regs.svh is available for constants
package sscc_pkg;

    typedef enum logic [2:0] {
        SSCC_PWR_RUN  = 3'b000,
        SSCC_PWR_STANDBY_CONTROL = 3'b001,
        SSCC_PWR_SHDN = 3'b010,
        SSCC_PWR_WAKE = 3'b011,
        SSCC_PWR_WRST = 3'b100
    } sscc_pwr_t;

    typedef enum logic [1:0] {
        SSCC_CST_IDLE  = 2'b00,
        SSCC_CST_ARMED = 2'b01,
        SSCC_CST_CONV  = 2'b10
    } sscc_cst_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sscc_bus_t;

    typedef struct packed {
        sscc_pwr_t   mode;
        logic [20:0] cnt;
        logic        fromShdn;
        logic        refOn;
        logic        coreOn;
        logic        ready;
        logic        wakeEvt;
    } sscc_pwr_state_t;

    typedef struct packed {
        sscc_cst_t   cst;
        logic        prevA;
        logic        prevB;
        logic        holdA;
        logic        holdB;
        logic        busy;
        logic [5:0]  slot;
        logic [2:0]  chan;
        logic        bank;
        logic [2:0]  rdPtr;
        logic        rangeCfg;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
        logic [31:0] rdData;
    } sscc_core_t;

endpackage : sscc_pkg

// File: src/sscc_result_mem.sv
// two banks of eight 16-bit channel results
// assumes one writer and one reader; read data registered
`timescale 1ns/100ps
`default_nettype none

module sscc_result_mem (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wrEn,
    input  wire logic [3:0]  wrAddr,
    input  wire logic [15:0] wrData,
    input  wire logic [3:0]  rdAddr,
    output logic      [15:0] rdData
);
    logic [15:0] words [16];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            words[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= 16'h0000;
        end else begin
            rdData <= words[rdAddr];
        end
    end
endmodule : sscc_result_mem

`default_nettype wire

// File: src/sscc_power_ctrl.sv
// power mode sequencer: run, standby, shutdown, wake-up and reset wait
// assumes standby and range pins synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "sscc_regs.svh"

module sscc_power_ctrl
    import sscc_pkg::*;
#(
    parameter int STANDBY_CONTROL_WAKE_CYC = `SSCC_STANDBY_CONTROL_WAKE_CYC,
    parameter int SHDN_WAKE_CYC = `SSCC_SHDN_WAKE_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic standbyControl,
    input  wire logic rangeSelect,
    input  wire logic deviceReset,
    output sscc_pwr_t pwrMode,
    output logic      refOn,
    output logic      coreOn,
    output logic      ready,
    output logic      wakeEvt
);
    sscc_pwr_state_t st_reg;
    sscc_pwr_state_t st_next;

    always_comb begin
        st_next         = st_reg;
        st_next.wakeEvt = 1'b0;
        case (st_reg.mode)
            SSCC_PWR_RUN: begin
                if (!standbyControl) begin
                    st_next.mode = rangeSelect ? SSCC_PWR_STANDBY_CONTROL
                                               : SSCC_PWR_SHDN;
                end
            end
            SSCC_PWR_STANDBY_CONTROL, SSCC_PWR_SHDN: begin
                if (standbyControl) begin
                    st_next.mode     = SSCC_PWR_WAKE;
                    st_next.fromShdn = (st_reg.mode == SSCC_PWR_SHDN);
                    st_next.cnt      = (st_reg.mode == SSCC_PWR_SHDN)
                                     ? 21'(SHDN_WAKE_CYC - 1)
                                     : 21'(STANDBY_CONTROL_WAKE_CYC - 1);
                end else begin
                    st_next.mode = rangeSelect ? SSCC_PWR_STANDBY_CONTROL
                                               : SSCC_PWR_SHDN;
                end
            end
            SSCC_PWR_WAKE: begin
                if (!standbyControl) begin
                    st_next.mode = rangeSelect ? SSCC_PWR_STANDBY_CONTROL
                                               : SSCC_PWR_SHDN;
                end else if (st_reg.cnt == 21'h000000) begin
                    // after shutdown the part only runs once reset again
                    st_next.mode    = st_reg.fromShdn ? SSCC_PWR_WRST
                                                      : SSCC_PWR_RUN;
                    st_next.wakeEvt = !st_reg.fromShdn;
                end else begin
                    st_next.cnt = st_reg.cnt - 21'h000001;
                end
            end
            SSCC_PWR_WRST: begin
                if (!standbyControl) begin
                    st_next.mode = rangeSelect ? SSCC_PWR_STANDBY_CONTROL
                                               : SSCC_PWR_SHDN;
                end else if (deviceReset) begin
                    st_next.mode    = SSCC_PWR_RUN;
                    st_next.wakeEvt = 1'b1;
                end
            end
            default: st_next.mode = SSCC_PWR_RUN;
        endcase
        // standby keeps reference alive, shutdown drops everything
        st_next.refOn  = (st_next.mode != SSCC_PWR_SHDN);
        st_next.coreOn = (st_next.mode != SSCC_PWR_SHDN)
                      && (st_next.mode != SSCC_PWR_STANDBY_CONTROL);
        st_next.ready  = (st_next.mode == SSCC_PWR_RUN);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{mode: SSCC_PWR_RUN, cnt: 21'h000000,
                        fromShdn: 1'b0, refOn: 1'b1, coreOn: 1'b1,
                        ready: 1'b1, wakeEvt: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pwrMode = st_reg.mode;
    assign refOn   = st_reg.refOn;
    assign coreOn  = st_reg.coreOn;
    assign ready   = st_reg.ready;
    assign wakeEvt = st_reg.wakeEvt;

    default clocking pcb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_STANDBY_CONTROL_ENTER: assert property (
        (st_reg.mode == SSCC_PWR_RUN && !standbyControl && rangeSelect)
        |=> (st_reg.mode == SSCC_PWR_STANDBY_CONTROL && st_reg.refOn && !st_reg.coreOn))
        else $error("standby not entered");
    AST_SHDN_ENTER: assert property (
        (st_reg.mode == SSCC_PWR_RUN && !standbyControl && !rangeSelect)
        |=> (st_reg.mode == SSCC_PWR_SHDN && !st_reg.refOn && !st_reg.ready))
        else $error("shutdown not entered");
    AST_WAKE_STANDBY_CONTROL: assert property (
        (st_reg.mode == SSCC_PWR_STANDBY_CONTROL && standbyControl)
        |=> (st_reg.mode == SSCC_PWR_WAKE
             && st_reg.cnt == 21'(STANDBY_CONTROL_WAKE_CYC - 1)))
        else $error("standby wake time wrong");
    AST_WAKE_SHDN: assert property (
        (st_reg.mode == SSCC_PWR_SHDN && standbyControl)
        |=> (st_reg.mode == SSCC_PWR_WAKE
             && st_reg.cnt == 21'(SHDN_WAKE_CYC - 1)))
        else $error("shutdown wake time wrong");
    AST_WAIT_RESET: assert property (
        (st_reg.mode == SSCC_PWR_WRST && standbyControl && !deviceReset)
        |=> (st_reg.mode == SSCC_PWR_WRST && !st_reg.ready))
        else $error("left reset wait without reset");
endmodule : sscc_power_ctrl

`default_nettype wire

// File: testbench/sscc_host_model.sv
// host pin model: start, power and reset pins, analog core samples
// assumes calls from the bench between clock edges
`timescale 1ns/100ps
`default_nettype none

module sscc_host_model (
    input  wire logic        clk,
    input  wire logic [2:0]  coreChannel,
    input  wire logic [15:0] base,
    output logic             sampleStartA,
    output logic             sampleStartB,
    output logic             standbyControl,
    output logic             rangeSelect,
    output logic             deviceReset,
    output logic      [15:0] coreSample
);
    // channel folded in so a swapped channel shows in readout
    assign coreSample = base ^ {13'h0, coreChannel};
    initial begin
        {sampleStartA, sampleStartB, rangeSelect, deviceReset} = 4'h0;
        standbyControl = 1'b1;
    end
    // skew between the two starts kept to a few cycles by callers
    task automatic start(input logic a, input logic b);
        sampleStartA <= a;
        sampleStartB <= b;
    endtask : start
    task automatic power(input logic run, input logic rng);
        standbyControl <= run;
        rangeSelect    <= rng;
    endtask : power
    // callers pulse only after power-up time has run out
    task automatic resetPulse();
        @(posedge clk);
        deviceReset <= 1'b1;
        @(posedge clk);
        deviceReset <= 1'b0;
    endtask : resetPulse
endmodule : sscc_host_model
`default_nettype wire

// File: testbench/simultaneous_sample_conversion_control_tb.sv
// self-checking bench for the conversion control block
// assumes the host model drives the start, power and reset pins and core samples; the bench drives oversampleOn
`timescale 1ns/100ps
`default_nettype none

module simultaneous_sample_conversion_control_tb
    import sscc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn;
    sscc_bus_t   regBus;
    logic [31:0] rdData;
    logic        irq, busy, holdLow, holdHigh, deviceReady;
    logic        refPowered, corePowered, rdLast = 1'b0;
    logic        rangeApplied, ovs = 1'b0;
    logic        sA, sB, standby_control, rng, dRst;
    logic [2:0]  coreChannel;
    logic [15:0] coreSample, prevBase, base = 16'h0;
    logic [31:0] lfsrState = 32'hd0e6;
    logic [31:0] expQ[$];
    int          mismatches = 0, checked = 0, n;

    always #5 clk = ~clk;

    sscc_conv_ctrl #(.STANDBY_CONTROL_WAKE_CYC(20), .SHDN_WAKE_CYC(30)) i_dut (
        .clk(clk), .rstn(rstn), .regBus(regBus), .rdData(rdData),
        .irq(irq), .standbyControl(standby_control), .rangeSelect(rng),
        .deviceReset(dRst), .sampleStartA(sA), .sampleStartB(sB),
        .oversampleOn(ovs), .coreSample(coreSample), .busy(busy),
        .holdLow(holdLow), .holdHigh(holdHigh), .coreChannel(coreChannel),
        .rangeApplied(rangeApplied), .refPowered(refPowered),
        .corePowered(corePowered), .deviceReady(deviceReady));

    sscc_host_model i_host (
        .clk(clk), .coreChannel(coreChannel), .base(base),
        .sampleStartA(sA), .sampleStartB(sB), .standbyControl(standby_control),
        .rangeSelect(rng), .deviceReset(dRst), .coreSample(coreSample));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic stop_test();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : check

    // strobe held between back-to-back cycles, dropped by idle or by a call of the other task
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regBus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        expQ.push_back(e);
        @(posedge clk);
    endtask : rd
    task automatic idle();
        regBus <= '0;
        @(posedge clk);
    endtask : idle

    always @(posedge clk) rdLast <= regBus.rd;
    always @(negedge clk) begin
        if (rdLast === 1'b1 && expQ.size() > 0) begin
            check("rdData", expQ.pop_front(), rdData);
        end
    end

    task automatic waitReady();
        n = 0;
        while (deviceReady !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1000) begin
            mismatches++;
            stop_test();
        end
    endtask : waitReady

    task automatic convert(input int gap, input bit readPrev);
        prevBase = base;
        lfsrState = lfsr(lfsrState);
        base <= lfsrState[15:0];
        i_host.start(1'b1, gap == 0 && !ovs);
        @(posedge clk);
        @(negedge clk);
        check("holdLow", 1'b1, holdLow);
        if (gap > 0) begin
            check("early", 1'b0, busy | holdHigh);
            repeat (gap) @(posedge clk);
            i_host.start(1'b1, 1'b1);
            @(posedge clk);
            @(negedge clk);
        end
        check("holdHigh", 1'b1, holdHigh);
        check("busy rise", 1'b1, busy);
        n = 1;
        fork
            while (busy === 1'b1 && n < 1000) begin
                @(negedge clk);
                if (busy === 1'b1) n++;
            end
            begin
                @(posedge clk);
                i_host.start(1'b0, 1'b0);
                repeat (7) @(posedge clk);
                i_host.start(1'b1, 1'b1);
                repeat (3) @(posedge clk);
                i_host.start(1'b0, 1'b0);
            end
            if (readPrev) begin
                @(posedge clk);
                for (int i = 0; i < 8; i++) begin
                    rd(8'h0c, {16'h0, prevBase ^ 16'(i)});
                end
                idle();
            end
        join
        check("busy cycles", 32'd400, n);
        check("holds", 2'b00, {holdLow, holdHigh});
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(8'h0c, {16'h0, base ^ 16'(i)});
        end
        idle();
    endtask : convert

    initial begin
        regBus = '0;
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        i_host.power(1'b1, 1'b1);
        i_host.resetPulse();
        rd(8'h08, 32'h88);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h04, 32'h1);
        idle();
        convert(0, 1'b0);
        check("irq set", 1'b1, irq);
        rd(8'h00, 32'h3);
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h0);
        idle();
        @(negedge clk);
        check("irq clear", 1'b0, irq);
        @(posedge clk);
        convert(5, 1'b1);
        check("irq masked", 1'b0, irq);
        ovs <= 1'b1;
        convert(0, 1'b0);
        ovs <= 1'b0;
        rd(8'h00, 32'h3);
        wr(8'h00, 32'h7);
        idle();
        i_host.power(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        check("standby_control", 3'b100, {refPowered, corePowered, deviceReady});
        @(posedge clk);
        i_host.power(1'b1, 1'b1);
        waitReady();
        check("wake time", 1'b1, n >= 20 && n <= 26);
        @(posedge clk);
        rd(8'h00, 32'h4);
        idle();
        i_host.power(1'b0, 1'b0);
        repeat (3) @(negedge clk);
        check("shdn", 3'b000, {refPowered, corePowered, deviceReady});
        @(posedge clk);
        i_host.power(1'b1, 1'b0);
        repeat (60) @(negedge clk);
        check("no reset", 1'b0, deviceReady);
        i_host.resetPulse();
        waitReady();
        check("ready", 1'b1, deviceReady);
        check("rangeApplied", 1'b0, rangeApplied);
        stop_test();
    end
endmodule : simultaneous_sample_conversion_control_tb
`default_nettype wire
